// *** shared/aic_pkg.sv ***
package aic_pkg;
   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int SCL_MAX_HZ = 400_000;
   localparam int QTR_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
   localparam logic [3:0] QTR_LAST = 4'(QTR_CYC - 1);
   localparam logic [1:0] PH_DRIVE = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h1;
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] PH_FALL = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Serial framing
   localparam logic [6:0] DEV_ADDR = 7'h6f;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] BYTE_DEV = 2'h0;
   localparam logic [1:0] BYTE_REG = 2'h1;
   localparam logic [1:0] BYTE_DATA = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Device registers
   localparam int NUM_REGS = 4;
   localparam logic [7:0] REG_POWER = 8'h00;
   localparam logic [7:0] REG_LIMITER = 8'h01;
   localparam logic [7:0] REG_GAIN = 8'h02;
   localparam logic [7:0] REG_TEST = 8'h03;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int PWR_EN_BIT = 0;
   localparam int BOOST_BIT = 1;
   localparam int INSEL_BIT = 2;
   localparam int FAST_WU_BIT = 3;
   localparam int REL_LSB = 5;
   localparam int ATK_LSB = 3;
   localparam int LVL_LSB = 0;
   localparam int GAIN_LSB = 0;
   localparam logic [3:0] WAKE_NORMAL_MS = 4'hf;
   localparam logic [3:0] WAKE_FAST_MS = 4'h5;
   localparam logic [3:0][4:0] GAIN_PLAIN_DB = {5'h12, 5'h0c, 5'h06, 5'h00};
   localparam logic [3:0][4:0] GAIN_BOOST_DB = {5'h1e, 5'h1b, 5'h18, 5'h15};
   localparam logic [3:0][4:0] HW_GAIN_DB = {5'h1e, 5'h18, 5'h06, 5'h00};

   // Synchroniser lanes of the device
   localparam int SY_SCL = 0;
   localparam int SY_SDA = 1;
   localparam int SY_CSS = 2;
   localparam int SY_PD = 3;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Controller command port
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] RDATA_OFS = 8'h08;
   localparam int CMD_REG_LSB = 0;
   localparam int CMD_DATA_LSB = 8;
   localparam int CMD_READ_BIT = 16;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_NACK_BIT = 1;

   typedef enum logic [2:0] {DEV_IDLE, DEV_RX, DEV_ACKWAIT, DEV_ACK, DEV_TX, DEV_MACK} aic_dev_e;
   typedef enum logic [1:0] {MST_IDLE, MST_START, MST_BIT, MST_STOP} aic_mst_e;

   function automatic logic [4:0] limit_vpp(input logic [2:0] code);
      case (code)
         3'h1: return 5'h0e;
         3'h2: return 5'h11;
         3'h3: return 5'h14;
         3'h4: return 5'h16;
         3'h5: return 5'h19;
         3'h6: return 5'h1c;
         default: return 5'h00;
      endcase
   endfunction
endpackage

// *** shared/aic_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface aic_link_if;
   logic scl;
   logic sda_m_out;
   logic sda_m_oe;
   logic sda_d_out;
   logic sda_d_oe;
   logic sda;

   // Open-drain wired level of the data line
   assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_d_oe & ~sda_d_out));

   modport master (output scl, output sda_m_out, output sda_m_oe, input sda);
   modport device (input scl, output sda_d_out, output sda_d_oe, input sda);
endinterface
`default_nettype wire

// *** hdl/aic_device.sv ***
// Local design decision: register writes take effect at the stop condition.
`timescale 1ns/100ps
`default_nettype none
module aic_device (
   input wire logic clk,
   input wire logic reset,
   aic_link_if.device lnk,
   input wire logic control_source_select,
   input wire logic power_down_pin,
   output logic power_down_n,
   output logic supply_boost_enable,
   output logic second_input_sel,
   output logic [3:0] wakeup_ms,
   output logic [1:0] release_code,
   output logic [1:0] attack_code,
   output logic [4:0] limit_vpp,
   output logic output_limiter,
   output logic [4:0] gain_db
);
   typedef struct packed {
      logic [3:0] sy1;
      logic [3:0] sy2;
      logic [3:0] sy3;
      logic [3:0] filt;
      aic_pkg::aic_dev_e st;
      logic [3:0] cnt;
      logic [1:0] byte_ix;
      logic [7:0] sh;
      logic rw;
      logic [7:0] regaddr;
      logic [7:0] wdata;
      logic wpend;
      logic sda_oe;
      logic [aic_pkg::NUM_REGS-1:0][7:0] regs;
      logic pwr_n;
      logic boost;
      logic insel;
      logic [3:0] wake;
      logic [1:0] rel;
      logic [1:0] atk;
      logic [4:0] vpp;
      logic lim;
      logic [4:0] gain;
   } aic_dev_s;

   aic_dev_s r;
   aic_dev_s n;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic sw_mode;
   logic [7:0] rd_sel;
   logic [7:0] pwr_reg;
   logic [7:0] lim_reg;
   logic [7:0] gain_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      n = r;
      n.sy1 = {power_down_pin, control_source_select, lnk.sda, lnk.scl};
      n.sy2 = r.sy1;
      n.sy3 = r.sy2;
      n.filt = (r.sy2 & r.sy3) | (r.filt & (r.sy2 ^ r.sy3));
      scl_rise = n.filt[aic_pkg::SY_SCL] & ~r.filt[aic_pkg::SY_SCL];
      scl_fall = ~n.filt[aic_pkg::SY_SCL] & r.filt[aic_pkg::SY_SCL];
      start_seen = n.filt[aic_pkg::SY_SCL] & r.filt[aic_pkg::SY_SCL]
         & r.filt[aic_pkg::SY_SDA] & ~n.filt[aic_pkg::SY_SDA];
      stop_seen = n.filt[aic_pkg::SY_SCL] & r.filt[aic_pkg::SY_SCL]
         & ~r.filt[aic_pkg::SY_SDA] & n.filt[aic_pkg::SY_SDA];
      sw_mode = r.filt[aic_pkg::SY_CSS];
      rd_sel = (r.regaddr < 8'(aic_pkg::NUM_REGS)) ? r.regs[r.regaddr[1:0]] : 8'h00;
      pwr_reg = r.regs[aic_pkg::REG_POWER[1:0]];
      lim_reg = r.regs[aic_pkg::REG_LIMITER[1:0]];
      gain_reg = r.regs[aic_pkg::REG_GAIN[1:0]];

      // Serial slave engine
      if (!sw_mode) begin
         n.st = aic_pkg::DEV_IDLE;
         n.sda_oe = 1'h0;
         n.wpend = 1'h0;
      end else if (start_seen) begin
         n.st = aic_pkg::DEV_RX;
         n.byte_ix = aic_pkg::BYTE_DEV;
         n.cnt = 4'h0;
         n.sda_oe = 1'h0;
         n.wpend = 1'h0;
      end else if (stop_seen) begin
         if (r.wpend && r.regaddr < 8'(aic_pkg::NUM_REGS)) begin
            n.regs[r.regaddr[1:0]] = r.wdata;
         end
         n.wpend = 1'h0;
         n.sda_oe = 1'h0;
         n.st = aic_pkg::DEV_IDLE;
      end else begin
         case (r.st)
            aic_pkg::DEV_RX: begin
               if (scl_rise) begin
                  n.sh = {r.sh[6:0], n.filt[aic_pkg::SY_SDA]};
                  n.cnt = r.cnt + 4'h1;
                  if (r.cnt == aic_pkg::BIT_LAST) begin
                     n.st = aic_pkg::DEV_ACKWAIT;
                  end
               end
            end
            aic_pkg::DEV_ACKWAIT: begin
               if (scl_fall) begin
                  if (r.byte_ix == aic_pkg::BYTE_DEV && r.sh[7:1] != aic_pkg::DEV_ADDR) begin
                     n.st = aic_pkg::DEV_IDLE;
                  end else begin
                     n.sda_oe = 1'h1;
                     n.st = aic_pkg::DEV_ACK;
                  end
                  if (r.byte_ix == aic_pkg::BYTE_DEV) begin
                     n.rw = r.sh[0];
                  end
                  if (r.byte_ix == aic_pkg::BYTE_REG) begin
                     n.regaddr = r.sh;
                  end
                  if (r.byte_ix == aic_pkg::BYTE_DATA) begin
                     n.wdata = r.sh;
                     n.wpend = 1'h1;
                  end
               end
            end
            aic_pkg::DEV_ACK: begin
               if (scl_fall) begin
                  n.sda_oe = 1'h0;
                  n.cnt = 4'h0;
                  n.byte_ix = r.byte_ix + 2'h1;
                  if (r.byte_ix == aic_pkg::BYTE_REG && r.rw) begin
                     n.sh = rd_sel;
                     n.sda_oe = ~rd_sel[7];
                     n.st = aic_pkg::DEV_TX;
                  end else if (r.byte_ix == aic_pkg::BYTE_DATA) begin
                     n.st = aic_pkg::DEV_IDLE;
                  end else begin
                     n.st = aic_pkg::DEV_RX;
                  end
               end
            end
            aic_pkg::DEV_TX: begin
               if (scl_rise) begin
                  n.cnt = r.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (r.cnt == aic_pkg::BYTE_BITS) begin
                     n.sda_oe = 1'h0;
                     n.st = aic_pkg::DEV_MACK;
                  end else begin
                     n.sda_oe = ~r.sh[~r.cnt[2:0]];
                  end
               end
            end
            aic_pkg::DEV_MACK: begin
               if (scl_rise) begin
                  n.st = aic_pkg::DEV_IDLE;
               end
            end
            default: begin
               n.st = aic_pkg::DEV_IDLE;
            end
         endcase
      end

      // Control outputs
      n.rel = lim_reg[aic_pkg::REL_LSB +: 2];
      n.atk = lim_reg[aic_pkg::ATK_LSB +: 2];
      if (sw_mode) begin
         n.pwr_n = r.filt[aic_pkg::SY_PD] & pwr_reg[aic_pkg::PWR_EN_BIT];
         n.boost = pwr_reg[aic_pkg::BOOST_BIT];
         n.insel = pwr_reg[aic_pkg::INSEL_BIT];
         n.wake = pwr_reg[aic_pkg::FAST_WU_BIT] ? aic_pkg::WAKE_FAST_MS
            : aic_pkg::WAKE_NORMAL_MS;
         n.lim = pwr_reg[aic_pkg::BOOST_BIT];
         n.vpp = pwr_reg[aic_pkg::BOOST_BIT]
            ? aic_pkg::limit_vpp(lim_reg[aic_pkg::LVL_LSB +: 3]) : 5'h00;
         n.gain = pwr_reg[aic_pkg::BOOST_BIT]
            ? aic_pkg::GAIN_BOOST_DB[gain_reg[aic_pkg::GAIN_LSB +: 2]]
            : aic_pkg::GAIN_PLAIN_DB[gain_reg[aic_pkg::GAIN_LSB +: 2]];
      end else begin
         n.pwr_n = r.filt[aic_pkg::SY_PD];
         n.boost = r.filt[aic_pkg::SY_SDA];
         n.insel = r.filt[aic_pkg::SY_SDA];
         n.wake = aic_pkg::WAKE_NORMAL_MS;
         n.lim = 1'h0;
         n.vpp = 5'h00;
         n.gain = aic_pkg::HW_GAIN_DB[{r.filt[aic_pkg::SY_SDA], r.filt[aic_pkg::SY_SCL]}];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
         r.st <= aic_pkg::DEV_IDLE;
         r.regs <= {aic_pkg::NUM_REGS{aic_pkg::REG_RESET}};
         r.wake <= aic_pkg::WAKE_NORMAL_MS;
      end else begin
         r <= n;
      end
   end

   assign lnk.sda_d_out = 1'h0;
   assign lnk.sda_d_oe = r.sda_oe;
   assign power_down_n = r.pwr_n;
   assign supply_boost_enable = r.boost;
   assign second_input_sel = r.insel;
   assign wakeup_ms = r.wake;
   assign release_code = r.rel;
   assign attack_code = r.atk;
   assign limit_vpp = r.vpp;
   assign output_limiter = r.lim;
   assign gain_db = r.gain;
endmodule
`default_nettype wire

// *** hdl/aic_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module aic_master (
   input wire logic clk,
   input wire logic reset,
   aic_link_if.master lnk,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   typedef struct packed {
      logic [2:0] sy;
      logic filt;
      logic [3:0] qcnt;
      aic_pkg::aic_mst_e st;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [1:0] byten;
      logic rd_op;
      logic [7:0] regaddr;
      logic [7:0] txdata;
      logic [7:0] rxdata;
      logic [7:0] result;
      logic fail;
      logic nack;
      logic scl;
      logic sda_oe;
      logic [31:0] rdata;
   } aic_mst_s;

   aic_mst_s r;
   aic_mst_s n;
   logic tick;
   logic busy;
   logic tx_byte;
   logic [7:0] cur_byte;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      n = r;
      n.sy = {r.sy[1:0], lnk.sda};
      n.filt = (r.sy[1] & r.sy[2]) | (r.filt & (r.sy[1] ^ r.sy[2]));
      busy = (r.st != aic_pkg::MST_IDLE);
      tick = busy && (r.qcnt == aic_pkg::QTR_LAST);
      n.qcnt = (busy && !tick) ? r.qcnt + 4'h1 : 4'h0;
      tx_byte = (r.byten != aic_pkg::BYTE_DATA) || !r.rd_op;
      case (r.byten)
         aic_pkg::BYTE_DEV: cur_byte = {aic_pkg::DEV_ADDR, r.rd_op};
         aic_pkg::BYTE_REG: cur_byte = r.regaddr;
         default: cur_byte = r.txdata;
      endcase

      // Command port
      n.rdata = 32'h0000_0000;
      if (rd) begin
         case (addr)
            aic_pkg::CMD_OFS: n.rdata = {15'h0000, r.rd_op, r.txdata, r.regaddr};
            aic_pkg::STATUS_OFS: n.rdata = {30'h0000_0000, r.nack, busy};
            aic_pkg::RDATA_OFS: n.rdata = {24'h00_0000, r.result};
            default: n.rdata = 32'h0000_0000;
         endcase
      end
      if (wr && addr == aic_pkg::STATUS_OFS && wdata[aic_pkg::ST_NACK_BIT]) begin
         n.nack = 1'h0;
      end
      if (wr && addr == aic_pkg::CMD_OFS && !busy) begin
         n.regaddr = wdata[aic_pkg::CMD_REG_LSB +: 8];
         n.txdata = wdata[aic_pkg::CMD_DATA_LSB +: 8];
         n.rd_op = wdata[aic_pkg::CMD_READ_BIT];
         n.st = aic_pkg::MST_START;
         n.ph = aic_pkg::PH_DRIVE;
         n.fail = 1'h0;
      end

      // Bit sequencer, four quarters per clock period
      if (tick) begin
         n.ph = r.ph + 2'h1;
         case (r.st)
            aic_pkg::MST_START: begin
               case (r.ph)
                  aic_pkg::PH_DRIVE: n.sda_oe = 1'h0;
                  aic_pkg::PH_RISE: n.sda_oe = 1'h1;
                  aic_pkg::PH_SAMPLE: n.sda_oe = 1'h1;
                  default: begin
                     n.scl = 1'h0;
                     n.st = aic_pkg::MST_BIT;
                     n.bitn = 4'h0;
                     n.byten = aic_pkg::BYTE_DEV;
                  end
               endcase
            end
            aic_pkg::MST_BIT: begin
               case (r.ph)
                  aic_pkg::PH_DRIVE: begin
                     if (r.bitn == aic_pkg::BYTE_BITS) begin
                        n.sda_oe = !tx_byte;
                     end else begin
                        n.sda_oe = tx_byte && !cur_byte[~r.bitn[2:0]];
                     end
                  end
                  aic_pkg::PH_RISE: n.scl = 1'h1;
                  aic_pkg::PH_SAMPLE: begin
                     if (r.bitn != aic_pkg::BYTE_BITS && !tx_byte) begin
                        n.rxdata = {r.rxdata[6:0], r.filt};
                     end
                     if (r.bitn == aic_pkg::BYTE_BITS && tx_byte && r.filt) begin
                        n.fail = 1'h1;
                        n.nack = 1'h1;
                     end
                  end
                  default: begin
                     n.scl = 1'h0;
                     n.bitn = r.bitn + 4'h1;
                     if (r.bitn == aic_pkg::BYTE_BITS) begin
                        n.bitn = 4'h0;
                        n.byten = r.byten + 2'h1;
                        if (r.fail || r.byten == aic_pkg::BYTE_DATA) begin
                           n.st = aic_pkg::MST_STOP;
                        end
                     end
                  end
               endcase
            end
            aic_pkg::MST_STOP: begin
               case (r.ph)
                  aic_pkg::PH_DRIVE: n.sda_oe = 1'h1;
                  aic_pkg::PH_RISE: n.scl = 1'h1;
                  aic_pkg::PH_SAMPLE: n.sda_oe = 1'h0;
                  default: begin
                     n.st = aic_pkg::MST_IDLE;
                     if (r.rd_op && !r.fail) begin
                        n.result = r.rxdata;
                     end
                  end
               endcase
            end
            default: n.st = aic_pkg::MST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
         r.st <= aic_pkg::MST_IDLE;
         r.sy <= 3'h7;
         r.filt <= 1'h1;
         r.scl <= 1'h1;
      end else begin
         r <= n;
      end
   end

   assign lnk.scl = r.scl;
   assign lnk.sda_m_out = 1'h0;
   assign lnk.sda_m_oe = r.sda_oe;
   assign rdata = r.rdata;
endmodule
`default_nettype wire

// *** tb/aic_link_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module aic_link_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl,
   input wire logic sda_m_oe,
   input wire logic sda_d_oe,
   input wire logic sda
);
   localparam int PER_MIN = 50;
   logic scl_reg;
   logic sda_reg;
   logic [7:0] per_reg;
   logic [5:0] rise_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock period and clock count per frame
   always_ff @(posedge clk) begin
      if (reset) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         per_reg <= 8'hff;
         rise_reg <= 6'h00;
      end else begin
         scl_reg <= scl;
         sda_reg <= sda;
         if (scl && !scl_reg) begin
            per_reg <= 8'h01;
         end else if (per_reg != 8'hff) begin
            per_reg <= per_reg + 8'h01;
         end
         if (scl && scl_reg && sda_reg && !sda) begin
            rise_reg <= 6'h00;
         end else if (scl && !scl_reg) begin
            rise_reg <= rise_reg + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_reset_idle: assert property ($fell(reset) |-> scl && !sda_m_oe && !sda_d_oe)
      else $error("link not idle after reset");
   a_scl_period: assert property ($rose(scl) |-> per_reg >= PER_MIN)
      else $error("serial clock faster than allowed");
   a_dev_steady: assert property ($changed(sda_d_oe) |-> !scl)
      else $error("device changed data while clock high");
   a_start_cond: assert property ($rose(sda_m_oe) && scl && $past(scl) |-> $past(sda))
      else $error("start not from released line");
   a_stop_cond: assert property ($rose(sda) && scl && $past(scl) |-> !sda_d_oe)
      else $error("device holds data at stop");
   a_frame_clocks: assert property ($rose(sda) && scl && $past(scl) |-> rise_reg > 6'h01
      && (rise_reg % 6'h09) == 6'h01)
      else $error("frame not whole nine-clock bytes");
   a_ack_window: assert property ($rose(sda_d_oe) |-> ##[1:40] $rose(scl))
      else $error("device drive not followed by clock");
   a_ack_hold: assert property ($rose(sda_d_oe) |-> sda_d_oe[*8])
      else $error("device drive too short");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic control_source_select = 1'b1;
   logic power_down_pin = 1'b1;
   logic power_down_n, supply_boost_enable, second_input_sel, output_limiter;
   logic [3:0] wakeup_ms;
   logic [1:0] release_code, attack_code;
   logic [4:0] limit_vpp, gain_db;
   int error_cnt = 0;
   int comparisons = 0;
   localparam logic [7:0] LVL [8] = '{8'h00, 8'h0e, 8'h11, 8'h14, 8'h16, 8'h19, 8'h1c, 8'h00};
   localparam logic [7:0] GN [8] = '{8'h00, 8'h06, 8'h0c, 8'h12, 8'h15, 8'h18, 8'h1b, 8'h1e};

   aic_link_if lnk ();
   aic_master u_aic_master (.clk(clk), .reset(reset), .lnk(lnk.master), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   aic_device u_aic_device (.clk(clk), .reset(reset), .lnk(lnk.device),
      .control_source_select(control_source_select), .power_down_pin(power_down_pin),
      .power_down_n(power_down_n), .supply_boost_enable(supply_boost_enable),
      .second_input_sel(second_input_sel), .wakeup_ms(wakeup_ms),
      .release_code(release_code), .attack_code(attack_code), .limit_vpp(limit_vpp),
      .output_limiter(output_limiter), .gain_db(gain_db));
   aic_link_sva u_aic_link_sva (.clk(clk), .reset(reset), .scl(lnk.scl),
      .sda_m_oe(lnk.sda_m_oe), .sda_d_oe(lnk.sda_d_oe), .sda(lnk.sda));

   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic wait_idle();
      logic [31:0] st;
      st = 32'h1;
      for (int n = 0; n < 3000 && st[aic_pkg::ST_BUSY_BIT] !== 1'b0; n++) begin
         bus_rd(aic_pkg::STATUS_OFS, st);
      end
      if (st[aic_pkg::ST_BUSY_BIT] !== 1'b0) begin
         chk("busy", 8'h00, 8'(st[aic_pkg::ST_BUSY_BIT]));
         wrap_up();
      end
      repeat (2) @(posedge clk);
   endtask

   task automatic link_cmd(input logic [31:0] c);
      bus_wr(aic_pkg::CMD_OFS, c);
      wait_idle();
   endtask

   task automatic dev_wr(input logic [7:0] r, input logic [7:0] d);
      link_cmd({15'h0, 1'b0, d, r});
   endtask

   task automatic dev_rd(input logic [7:0] r, output logic [31:0] d);
      link_cmd({15'h0, 1'b1, 8'h00, r});
      bus_rd(aic_pkg::RDATA_OFS, d);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_power();
      dev_wr(aic_pkg::REG_POWER, 8'h0b);
      chk("power_down_n", 8'h01, 8'(power_down_n));
      chk("boost", 8'h01, 8'(supply_boost_enable));
      chk("input", 8'h00, 8'(second_input_sel));
      chk("wakeup", 8'h05, 8'(wakeup_ms));
      dev_wr(aic_pkg::REG_POWER, 8'h05);
      chk("boost", 8'h00, 8'(supply_boost_enable));
      chk("input", 8'h01, 8'(second_input_sel));
      chk("wakeup", 8'h0f, 8'(wakeup_ms));
      @(posedge clk);
      power_down_pin <= 1'b0;
      for (int n = 0; n < 20 && power_down_n !== 1'b0; n++) @(posedge clk);
      chk("power_down_n", 8'h00, 8'(power_down_n));
      power_down_pin <= 1'b1;
   endtask

   task automatic t_limiter();
      logic [7:0] v;
      dev_wr(aic_pkg::REG_POWER, 8'h03);
      for (int c = 0; c < 8; c++) begin
         v = {1'b0, 2'(c), ~2'(c), 3'(c)};
         dev_wr(aic_pkg::REG_LIMITER, v);
         chk("release", 8'(v[6:5]), 8'(release_code));
         chk("attack", 8'(v[4:3]), 8'(attack_code));
         chk("limit_vpp", LVL[c], 8'(limit_vpp));
         chk("limiter", 8'h01, 8'(output_limiter));
      end
      dev_wr(aic_pkg::REG_POWER, 8'h01);
      chk("limit_vpp", 8'h00, 8'(limit_vpp));
      chk("limiter", 8'h00, 8'(output_limiter));
   endtask

   task automatic t_gain();
      for (int b = 0; b < 2; b++) begin
         dev_wr(aic_pkg::REG_POWER, {6'h00, 1'(b), 1'b1});
         for (int g = 0; g < 4; g++) begin
            dev_wr(aic_pkg::REG_GAIN, 8'(g));
            chk("gain_db", GN[b * 4 + g], 8'(gain_db));
         end
      end
   endtask

   task automatic t_readback();
      logic [31:0] d;
      dev_wr(aic_pkg::REG_LIMITER, 8'h4d);
      dev_wr(8'h05, 8'h77);
      dev_rd(aic_pkg::REG_LIMITER, d);
      chk("reg_limiter", 8'h4d, d[7:0]);
      dev_rd(8'h05, d);
      chk("reg_high", 8'h00, d[7:0]);
      bus_rd(aic_pkg::STATUS_OFS, d);
      chk("nack", 8'h00, 8'(d[aic_pkg::ST_NACK_BIT]));
      bus_rd(8'h0c, d);
      chk("unmapped", 8'h00, d[7:0]);
   endtask

   task automatic t_pinmode();
      logic [31:0] d;
      @(posedge clk);
      control_source_select <= 1'b0;
      repeat (10) @(posedge clk);
      chk("input", 8'h01, 8'(second_input_sel));
      chk("gain_db", 8'h1e, 8'(gain_db));
      chk("boost", 8'h01, 8'(supply_boost_enable));
      chk("limiter", 8'h00, 8'(output_limiter));
      bus_wr(aic_pkg::CMD_OFS, 32'h0000_0102);
      for (int n = 0; n < 400 && gain_db !== 5'h06; n++) @(posedge clk);
      chk("gain_db", 8'h06, 8'(gain_db));
      chk("boost", 8'h00, 8'(supply_boost_enable));
      for (int n = 0; n < 400 && gain_db !== 5'h00; n++) @(posedge clk);
      chk("gain_db", 8'h00, 8'(gain_db));
      chk("input", 8'h00, 8'(second_input_sel));
      for (int n = 0; n < 400 && gain_db !== 5'h18; n++) @(posedge clk);
      chk("gain_db", 8'h18, 8'(gain_db));
      chk("input", 8'h01, 8'(second_input_sel));
      wait_idle();
      bus_rd(aic_pkg::STATUS_OFS, d);
      chk("nack", 8'h01, 8'(d[aic_pkg::ST_NACK_BIT]));
      bus_wr(aic_pkg::STATUS_OFS, 32'h2);
      bus_rd(aic_pkg::STATUS_OFS, d);
      chk("nack", 8'h00, 8'(d[aic_pkg::ST_NACK_BIT]));
      @(posedge clk);
      control_source_select <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (8) @(posedge clk);
      chk("wakeup", 8'h0f, 8'(wakeup_ms));
      t_power();
      t_limiter();
      t_gain();
      t_readback();
      t_pinmode();
      wrap_up();
   end
endmodule
`default_nettype wire
